// >>> verilog/ups_map.vh
// Overview of operation
// - bus idle beyond 3 ms sets suspend flag and pulses the usb interrupt
// - clearing the usb clock gate bit stops the usb clock
// - deep suspend lowers current; with low voltage reset option it requests reset
// - host resume sets resume flag and pulses the usb interrupt
// - resume flag clears first, suspend flag falls afterwards
// - end of resume drops suspend and pulses the usb interrupt again
// - remote wake pulse makes device drive wake signalling; host answers with resume
// - ps2 select one, usb select zero: d- is ps2 data, d+ ps2 clock
// - ps2 pin levels read in status bits 4,5; driven from bits 6,7
// - usb select alone lets the engine drive both usb lines
// - both interface select bits reset to zero
// - address register resets to zero; bit0 wake enable, bits 7..1 address, write-only
// - last accessed endpoint bit set in access register; bits 7..4 read zero
// - stall bit n halts endpoint n; usb bus reset clears it; bits 7..4 zero
// - auto address set: adopt address after good in read, then clear the bit
// - auto address clear: adopt address immediately on address register write
// - fifo0 error flag set by engine, cleared only by firmware, resets to zero
`ifndef UPS_MAP_VH
`define UPS_MAP_VH

// register offsets in the data memory space
`define UPS_OFS_STATUS_CONTROL 8'h1a
`define UPS_OFS_MODE 8'h1b
`define UPS_OFS_SYSCLK_CONTROL 8'h1c
`define UPS_OFS_ADDRESS_WAKE 8'h42
`define UPS_OFS_HALT 8'h43
`define UPS_OFS_LAST_ACCESSED 8'h44
`define UPS_OFS_SIGNAL_STATE 8'h45

// status/control field positions
`define UPS_SC_SUSPEND 0
`define UPS_SC_WAKE_PULSE 1
`define UPS_SC_RESUME 3
`define UPS_SC_DATA_IN 4
`define UPS_SC_CLOCK_IN 5
`define UPS_SC_DATA_OUT 6
`define UPS_SC_CLOCK_OUT 7

// mode, system clock control and signal state fields
`define UPS_MODE_PS2 4
`define UPS_MODE_USB 5
`define UPS_SYS_CLK_GATE 3
`define UPS_SYS_DEEP_SUSP 4
`define UPS_SIG_AUTO_ADDR 4
`define UPS_SIG_FIFO0_ERR 5

// reset values
`define UPS_RST_ADDRESS_WAKE 8'h00
`define UPS_RST_HALT 4'h0
`define UPS_RST_MODE 8'h00
`define UPS_RST_SYSCLK 8'h08
`define UPS_RST_PS2_OUT 2'h3

// timing
// sized to the timer width so the cycle products land on 20-bit parameters without truncation
// 40 mhz, 3000 us, 10000 us
`define UPS_CLK_MHZ 20'h28
`define UPS_IDLE_LIMIT_US 20'hbb8
`define UPS_WAKE_DRIVE_US 20'h2710
`define UPS_IDLE_CYCLES (`UPS_IDLE_LIMIT_US * `UPS_CLK_MHZ)
`define UPS_WAKE_CYCLES (`UPS_WAKE_DRIVE_US * `UPS_CLK_MHZ)
`define UPS_TIMER_W 20

`endif

// >>> verilog/ups_sync2.v
`timescale 1ns/1ps
module ups_sync2 #(
	parameter W = 2
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_resetn,
	// data
	input wire [W-1:0] i_async,
	output reg [W-1:0] o_sync
);
	reg [W-1:0] stage1;

	always @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			stage1 <= {W{1'b0}};
			o_sync <= {W{1'b0}};
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule

// >>> verilog/ups_timer.v
`timescale 1ns/1ps
`include "ups_map.vh"
module ups_timer #(
	parameter [`UPS_TIMER_W-1:0] LIMIT = 20'd16
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_resetn,
	// control
	input wire i_restart,
	input wire i_run,
	// status
	output reg o_expired
);
	reg [`UPS_TIMER_W-1:0] count;

	// saturates at the limit so a long idle never wraps back to active
	always @(posedge i_clk_sys) begin
		if (!i_resetn || i_restart) begin
			count <= {`UPS_TIMER_W{1'b0}};
			o_expired <= 1'b0;
		end else if (i_run && !o_expired) begin
			count <= count + 1'b1;
			o_expired <= (count == LIMIT - 1'b1);
		end
	end
endmodule

// >>> verilog/ups_sie_control.v
`timescale 1ns/1ps
`include "ups_map.vh"
module ups_sie_control #(
	parameter [`UPS_TIMER_W-1:0] IDLE_CYCLES = `UPS_IDLE_CYCLES,
	parameter [`UPS_TIMER_W-1:0] WAKE_CYCLES = `UPS_WAKE_CYCLES
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_resetn,
	// register port of the processor data memory
	input wire [7:0] i_addr,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] i_wdata,
	output reg [7:0] o_rdata,
	// usb line pins, d+ and d-
	input wire i_dp,
	input wire i_dm,
	output reg o_dp,
	output reg o_dp_oe,
	output reg o_dm,
	output reg o_dm_oe,
	// serial engine line drive and events
	input wire i_sie_dp,
	input wire i_sie_dm,
	input wire i_sie_oe,
	input wire i_usb_bus_reset,
	input wire i_ep_access,
	input wire [1:0] i_ep_num,
	input wire i_in_read_done,
	input wire i_fifo0_error,
	// engine and system controls
	input wire i_low_voltage_reset_option,
	output reg o_usb_irq,
	output reg o_usb_clock_gate_on,
	output reg o_deep_suspend,
	output reg o_reset_request,
	output reg [6:0] o_device_address_field,
	output reg o_remote_wake_enable,
	output reg [3:0] o_ep_halt
);
	////////////////////////////////////////////////////////////////////////
	// registers and state
	reg [7:0] address_wake;
	reg [7:0] interface_mode_reg;
	reg [7:0] system_clock_control;
	reg [3:0] ep_last_accessed;
	reg auto_address;
	reg fifo_zero_error;
	reg suspend;
	reg resume;
	reg resume_ending;
	reg kbd_data_out;
	reg kbd_clock_out;
	reg wake_active;
	reg [2:0] wake_tail;
	wire [1:0] line_sync;
	wire dp_s;
	wire dm_s;
	wire idle_expired;
	wire wake_done;
	wire ps2_mode;
	wire usb_mode;
	wire line_idle_j;
	wire line_k;
	wire kbd_data_in;
	wire kbd_clock_in;
	wire wr_sc;
	wire wr_mode;
	wire wr_sys;
	wire wr_addr;
	wire wr_halt;
	wire wr_sig;
	wire wake_start;
	reg [7:0] next_rdata;

	function hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	assign wr_sc = i_wr && hit(i_addr, `UPS_OFS_STATUS_CONTROL);
	assign wr_mode = i_wr && hit(i_addr, `UPS_OFS_MODE);
	assign wr_sys = i_wr && hit(i_addr, `UPS_OFS_SYSCLK_CONTROL);
	assign wr_addr = i_wr && hit(i_addr, `UPS_OFS_ADDRESS_WAKE);
	assign wr_halt = i_wr && hit(i_addr, `UPS_OFS_HALT);
	assign wr_sig = i_wr && hit(i_addr, `UPS_OFS_SIGNAL_STATE);

	////////////////////////////////////////////////////////////////////////
	// line sampling
	ups_sync2 #(
		.W(2)
	) u_line_sync (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_async({i_dp, i_dm}),
		.o_sync(line_sync)
	);

	assign dp_s = line_sync[1];
	assign dm_s = line_sync[0];
	assign ps2_mode = interface_mode_reg[`UPS_MODE_PS2] && !interface_mode_reg[`UPS_MODE_USB];
	assign usb_mode = !interface_mode_reg[`UPS_MODE_PS2] && interface_mode_reg[`UPS_MODE_USB];
	// low speed idle is d- high, d+ low; resume and wake are the opposite
	assign line_idle_j = !dp_s && dm_s;
	assign line_k = dp_s && !dm_s;
	// pin reads zero while the output bit pulls the line low
	assign kbd_data_in = dm_s && kbd_data_out;
	assign kbd_clock_in = dp_s && kbd_clock_out;

	////////////////////////////////////////////////////////////////////////
	// idle and wake timers
	// our own wake drive stops the idle count, and the K it puts on the line restarts it
	ups_timer #(
		.LIMIT(IDLE_CYCLES)
	) u_idle_timer (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_restart(!line_idle_j || !usb_mode),
		.i_run(!wake_active),
		.o_expired(idle_expired)
	);

	assign wake_start = wr_sc && i_wdata[`UPS_SC_WAKE_PULSE] && address_wake[0] && suspend && usb_mode;

	ups_timer #(
		.LIMIT(WAKE_CYCLES)
	) u_wake_timer (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_restart(!wake_active),
		.i_run(wake_active),
		.o_expired(wake_done)
	);

	////////////////////////////////////////////////////////////////////////
	// suspend, resume and remote wake
	always @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			suspend <= 1'b0;
			resume <= 1'b0;
			resume_ending <= 1'b0;
			wake_active <= 1'b0;
			wake_tail <= 3'h0;
			o_usb_irq <= 1'b0;
		end else begin
			o_usb_irq <= 1'b0;
			// our own wake drive still echoes through the synchroniser for a few cycles after release
			wake_tail <= {wake_tail[1:0], wake_active};
			if (wake_start) begin
				wake_active <= 1'b1;
			end else if (wake_done) begin
				wake_active <= 1'b0;
			end
			if (!suspend) begin
				if (idle_expired) begin
					suspend <= 1'b1;
					o_usb_irq <= 1'b1;
				end
			end else if (resume_ending) begin
				// suspend falls one cycle after resume has cleared
				resume_ending <= 1'b0;
				suspend <= 1'b0;
				o_usb_irq <= 1'b1;
			end else if (!resume) begin
				if (line_k && !wake_active && wake_tail == 3'h0 && usb_mode) begin
					resume <= 1'b1;
					o_usb_irq <= 1'b1;
				end
			end else if (!line_k) begin
				resume <= 1'b0;
				resume_ending <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// firmware registers
	always @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			interface_mode_reg <= `UPS_RST_MODE;
			system_clock_control <= `UPS_RST_SYSCLK;
			address_wake <= `UPS_RST_ADDRESS_WAKE;
			o_ep_halt <= `UPS_RST_HALT;
			{kbd_clock_out, kbd_data_out} <= `UPS_RST_PS2_OUT;
			auto_address <= 1'b0;
			fifo_zero_error <= 1'b0;
			ep_last_accessed <= 4'h0;
			o_device_address_field <= 7'h00;
			o_remote_wake_enable <= 1'b0;
		end else begin
			if (wr_mode) begin
				interface_mode_reg <= i_wdata;
			end
			if (wr_sys) begin
				system_clock_control <= i_wdata;
			end
			if (wr_sc) begin
				kbd_data_out <= i_wdata[`UPS_SC_DATA_OUT];
				kbd_clock_out <= i_wdata[`UPS_SC_CLOCK_OUT];
			end
			if (wr_addr) begin
				address_wake <= i_wdata;
				o_remote_wake_enable <= i_wdata[0];
			end
			if (i_usb_bus_reset) begin
				o_ep_halt <= 4'h0;
			end else if (wr_halt) begin
				o_ep_halt <= i_wdata[3:0];
			end
			if (i_ep_access) begin
				ep_last_accessed <= 4'h1 << i_ep_num;
			end
			// address adoption: immediate write, or deferred to a good in read
			if (wr_addr && !auto_address) begin
				o_device_address_field <= i_wdata[7:1];
			end else if (auto_address && i_in_read_done) begin
				o_device_address_field <= address_wake[7:1];
			end
			if (wr_sig) begin
				auto_address <= i_wdata[`UPS_SIG_AUTO_ADDR];
			end else if (auto_address && i_in_read_done) begin
				auto_address <= 1'b0;
			end
			// engine set wins over a firmware clear in the same cycle
			if (i_fifo0_error) begin
				fifo_zero_error <= 1'b1;
			end else if (wr_sig) begin
				fifo_zero_error <= i_wdata[`UPS_SIG_FIFO0_ERR];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pins and system controls
	always @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_dp <= 1'b0;
			o_dp_oe <= 1'b0;
			o_dm <= 1'b0;
			o_dm_oe <= 1'b0;
			o_usb_clock_gate_on <= 1'b1;
			o_deep_suspend <= 1'b0;
			o_reset_request <= 1'b0;
		end else begin
			o_usb_clock_gate_on <= system_clock_control[`UPS_SYS_CLK_GATE];
			o_deep_suspend <= system_clock_control[`UPS_SYS_DEEP_SUSP];
			// this pairing resets the chip; firmware is expected to avoid it
			o_reset_request <= system_clock_control[`UPS_SYS_DEEP_SUSP] && i_low_voltage_reset_option;
			if (ps2_mode) begin
				// open drain: drive low only, released otherwise
				o_dm <= 1'b0;
				o_dm_oe <= !kbd_data_out;
				o_dp <= 1'b0;
				o_dp_oe <= !kbd_clock_out;
			end else if (usb_mode && wake_active) begin
				o_dp <= 1'b1;
				o_dm <= 1'b0;
				o_dp_oe <= 1'b1;
				o_dm_oe <= 1'b1;
			end else if (usb_mode) begin
				o_dp <= i_sie_dp;
				o_dm <= i_sie_dm;
				o_dp_oe <= i_sie_oe;
				o_dm_oe <= i_sie_oe;
			end else begin
				o_dp <= 1'b0;
				o_dm <= 1'b0;
				o_dp_oe <= 1'b0;
				o_dm_oe <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path; write-only registers and unmapped offsets read zero
	always @* begin
		next_rdata = 8'h00;
		case (i_addr)
			`UPS_OFS_STATUS_CONTROL: begin
				next_rdata[`UPS_SC_SUSPEND] = suspend;
				next_rdata[`UPS_SC_RESUME] = resume;
				next_rdata[`UPS_SC_DATA_IN] = kbd_data_in;
				next_rdata[`UPS_SC_CLOCK_IN] = kbd_clock_in;
				next_rdata[`UPS_SC_DATA_OUT] = kbd_data_out;
				next_rdata[`UPS_SC_CLOCK_OUT] = kbd_clock_out;
			end
			`UPS_OFS_MODE: begin
				next_rdata = interface_mode_reg;
			end
			`UPS_OFS_SYSCLK_CONTROL: begin
				next_rdata = system_clock_control;
			end
			`UPS_OFS_LAST_ACCESSED: begin
				next_rdata = {4'h0, ep_last_accessed};
			end
			`UPS_OFS_SIGNAL_STATE: begin
				next_rdata[`UPS_SIG_AUTO_ADDR] = auto_address;
				next_rdata[`UPS_SIG_FIFO0_ERR] = fifo_zero_error;
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end
	end
endmodule

// >>> dv/ups_host_model.sv
`timescale 1ns/1ps
module ups_host_model #(
	parameter ANSWER_CYCLES = 8
) (
	// clock
	input wire i_clk_sys,
	// bench control: ps2 pull-ups, line command
	input wire i_ps2,
	input wire [1:0] i_cmd,
	// device pin drive
	input wire i_dev_dp,
	input wire i_dev_dp_oe,
	input wire i_dev_dm,
	input wire i_dev_dm_oe,
	// resolved wire levels
	output wire o_line_dp,
	output wire o_line_dm
);
	reg was_k = 1'b0;
	reg [3:0] answer_cnt = 4'h0;
	reg host_dp;
	reg host_dm;
	// usb: 0 idle, 1 resume K, 2 SE0; ps2: bit0/bit1 pull data/clock low against the pull-ups
	always @* begin
		if (i_ps2) begin
			host_dp = !i_cmd[1];
			host_dm = !i_cmd[0];
		end else if (answer_cnt != 4'h0 || i_cmd == 2'h1) begin
			host_dp = 1'b1;
			host_dm = 1'b0;
		end else begin
			host_dp = 1'b0;
			host_dm = i_cmd != 2'h2;
		end
	end
	// a wake drive from the device is answered with resume once it is released
	always @(posedge i_clk_sys) begin
		was_k <= i_dev_dp_oe && i_dev_dp && !i_dev_dm;
		if (was_k && !i_dev_dp_oe && !i_ps2)
			answer_cnt <= ANSWER_CYCLES;
		else if (answer_cnt != 4'h0)
			answer_cnt <= answer_cnt - 4'h1;
	end
	assign o_line_dp = i_dev_dp_oe ? i_dev_dp : host_dp;
	assign o_line_dm = i_dev_dm_oe ? i_dev_dm : host_dm;
endmodule

// >>> dv/ups_sie_control_monitor.sv
`timescale 1ns/1ps
module ups_sie_control_monitor (
	input wire i_clk_sys,
	input wire i_resetn,
	input wire [7:0] i_addr,
	input wire i_wr,
	input wire [7:0] i_wdata,
	input wire i_usb_bus_reset,
	input wire i_in_read_done,
	input wire i_low_voltage_reset_option,
	input wire o_usb_irq,
	input wire o_usb_clock_gate_on,
	input wire o_deep_suspend,
	input wire o_reset_request,
	input wire [6:0] o_device_address_field,
	input wire o_remote_wake_enable,
	input wire [3:0] o_ep_halt
);
	reg auto_on;
	reg [6:0] held_addr;
	wire wr_addr = i_wr && i_addr == 8'h42;
	// the deferred-address state is not visible at the ports, so shadow it
	always @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			auto_on <= 1'b0;
			held_addr <= 7'h00;
		end else begin
			if (i_wr && i_addr == 8'h45)
				auto_on <= i_wdata[4];
			else if (i_in_read_done)
				auto_on <= 1'b0;
			if (wr_addr)
				held_addr <= i_wdata[7:1];
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	AST_IRQ_ONE: assert property (o_usb_irq |=> !o_usb_irq)
		else $error("usb interrupt longer than one cycle");
	AST_ADDR_NOW: assert property (wr_addr && !auto_on |=> o_device_address_field == $past(i_wdata[7:1]))
		else $error("address not adopted at once");
	AST_WAKE_EN: assert property (wr_addr |=> o_remote_wake_enable == $past(i_wdata[0]))
		else $error("wake enable not stored");
	AST_ADDR_WAIT: assert property (auto_on && !i_in_read_done |=> $stable(o_device_address_field))
		else $error("address changed before in read");
	AST_ADDR_LATE: assert property (auto_on && i_in_read_done |=> o_device_address_field == held_addr)
		else $error("address not adopted after in read");
	AST_HALT_CLR: assert property (i_usb_bus_reset |=> o_ep_halt == 4'h0)
		else $error("halt not cleared by bus reset");
	AST_HALT_SET: assert property (i_wr && i_addr == 8'h43 && !i_usb_bus_reset |=> o_ep_halt == $past(i_wdata[3:0]))
		else $error("halt write lost");
	AST_CLK_CTRL: assert property (i_wr && i_addr == 8'h1c |-> ##2
		o_usb_clock_gate_on == $past(i_wdata[3], 2) && o_deep_suspend == $past(i_wdata[4], 2))
		else $error("clock control not applied");
	AST_RST_REQ: assert property (o_deep_suspend && i_low_voltage_reset_option |-> ##[0:2] o_reset_request)
		else $error("reset request missing");
endmodule
bind ups_sie_control ups_sie_control_monitor ups_sie_control_monitor_inst (.i_clk_sys, .i_resetn, .i_addr, .i_wr,
	.i_wdata, .i_usb_bus_reset, .i_in_read_done, .i_low_voltage_reset_option, .o_usb_irq, .o_usb_clock_gate_on,
	.o_deep_suspend, .o_reset_request, .o_device_address_field, .o_remote_wake_enable, .o_ep_halt);

// >>> dv/usb_ps2_sie_control_tb.sv
`timescale 1ns/1ps
module usb_ps2_sie_control_tb;
	reg i_clk_sys = 1'b0;
	reg i_resetn = 1'b0;
	reg [7:0] i_addr = 8'h00;
	reg i_wr = 1'b0;
	reg i_rd = 1'b0;
	reg [7:0] i_wdata = 8'h00;
	reg i_sie_dp = 1'b0;
	reg i_sie_dm = 1'b0;
	reg i_sie_oe = 1'b0;
	reg i_usb_bus_reset = 1'b0;
	reg i_ep_access = 1'b0;
	reg [1:0] i_ep_num = 2'h0;
	reg i_in_read_done = 1'b0;
	reg i_fifo0_error = 1'b0;
	reg i_low_voltage_reset_option = 1'b0;
	reg ps2_host = 1'b0;
	reg [1:0] host_cmd = 2'h2;
	wire [7:0] o_rdata;
	wire o_dp, o_dp_oe, o_dm, o_dm_oe, line_dp, line_dm;
	wire o_usb_irq, o_usb_clock_gate_on, o_deep_suspend, o_reset_request, o_remote_wake_enable;
	wire [6:0] o_device_address_field;
	wire [3:0] o_ep_halt;
	integer error_cnt = 0;
	integer n_compared = 0;
	integer n;
	ups_sie_control #(.IDLE_CYCLES(20'd20), .WAKE_CYCLES(20'd30)) ups_sie_control_inst (.i_clk_sys, .i_resetn,
		.i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .i_dp(line_dp), .i_dm(line_dm), .o_dp, .o_dp_oe, .o_dm, .o_dm_oe,
		.i_sie_dp, .i_sie_dm, .i_sie_oe, .i_usb_bus_reset, .i_ep_access, .i_ep_num, .i_in_read_done, .i_fifo0_error,
		.i_low_voltage_reset_option, .o_usb_irq, .o_usb_clock_gate_on, .o_deep_suspend, .o_reset_request,
		.o_device_address_field, .o_remote_wake_enable, .o_ep_halt);
	ups_host_model ups_host_model_inst (.i_clk_sys, .i_ps2(ps2_host), .i_cmd(host_cmd), .i_dev_dp(o_dp),
		.i_dev_dp_oe(o_dp_oe), .i_dev_dm(o_dm), .i_dev_dm_oe(o_dm_oe), .o_line_dp(line_dp), .o_line_dm(line_dm));
	////////////////////////////////////////////////////////////////
	initial begin
		forever #12.5 i_clk_sys = !i_clk_sys;
	end
	task finish_test;
		begin
			if (error_cnt == 0 && n_compared > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task chk(input string nm, input [7:0] exp, input [7:0] got);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("BAD %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task tick(input integer k);
		begin
			repeat (k) @(posedge i_clk_sys);
			#1;
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			tick(1);
			i_addr = a;
			i_wdata = d;
			i_wr = 1'b1;
			tick(1);
			i_wr = 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] mask, input [7:0] exp, input string nm);
		begin
			tick(1);
			i_addr = a;
			i_rd = 1'b1;
			tick(1);
			i_rd = 1'b0;
			chk(nm, exp, o_rdata & mask);
		end
	endtask
	// irq is a one-cycle pulse, so poll every cycle; a missing one ends the run
	task wirq(input string nm);
		integer k;
		begin
			k = 0;
			while (o_usb_irq !== 1'b1 && k < 200) begin
				tick(1);
				k = k + 1;
			end
			chk(nm, 8'h01, {7'h00, o_usb_irq});
			if (o_usb_irq !== 1'b1)
				finish_test;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		tick(12);
		i_resetn = 1'b1;
		chk("pins", 8'h04, {o_usb_clock_gate_on, o_deep_suspend, o_reset_request});
		rd(8'h1b, 8'hff, 8'h00, "mode");
		rd(8'h1c, 8'hff, 8'h08, "sysclk");
		rd(8'h42, 8'hff, 8'h00, "address");
		rd(8'h43, 8'hff, 8'h00, "halt");
		rd(8'h44, 8'hff, 8'h00, "last_ep");
		rd(8'h45, 8'hff, 8'h00, "signal");
		rd(8'h50, 8'hff, 8'h00, "unmapped");
		wr(8'h42, 8'hab);
		chk("addr_now", 8'hab, {o_device_address_field, o_remote_wake_enable});
		rd(8'h42, 8'hff, 8'h00, "addr_wo");
		wr(8'h45, 8'h10);
		wr(8'h42, 8'h24);
		tick(2);
		chk("addr_wait", 8'haa, {o_device_address_field, o_remote_wake_enable});
		i_in_read_done = 1'b1;
		tick(1);
		i_in_read_done = 1'b0;
		tick(1);
		chk("addr_late", 8'h24, {o_device_address_field, o_remote_wake_enable});
		rd(8'h45, 8'hff, 8'h00, "auto_clear");
		i_fifo0_error = 1'b1;
		tick(1);
		i_fifo0_error = 1'b0;
		rd(8'h45, 8'hff, 8'h20, "fifo0_err");
		wr(8'h45, 8'h00);
		rd(8'h45, 8'hff, 8'h00, "fifo0_clr");
		for (n = 0; n < 4; n = n + 1) begin
			i_ep_access = 1'b1;
			i_ep_num = n[1:0];
			tick(1);
			i_ep_access = 1'b0;
			rd(8'h44, 8'hff, 8'h01 << n, "last_ep");
		end
		wr(8'h43, 8'hff);
		chk("halt_set", 8'h0f, {4'h0, o_ep_halt});
		rd(8'h43, 8'hff, 8'h00, "halt_wo");
		i_usb_bus_reset = 1'b1;
		tick(1);
		i_usb_bus_reset = 1'b0;
		tick(1);
		chk("halt_clr", 8'h00, {4'h0, o_ep_halt});
		wr(8'h1c, 8'h10);
		i_low_voltage_reset_option = 1'b1;
		tick(3);
		chk("deep_lvr", 8'h03, {o_usb_clock_gate_on, o_deep_suspend, o_reset_request});
		i_low_voltage_reset_option = 1'b0;
		wr(8'h1c, 8'h08);
		tick(2);
		chk("clk_on", 8'h04, {o_usb_clock_gate_on, o_deep_suspend, o_reset_request});
		// ps2: clock pin driven low, data released and pulled up by the host side
		ps2_host = 1'b1;
		host_cmd = 2'h0;
		wr(8'h1b, 8'h10);
		wr(8'h1a, 8'h40);
		tick(2);
		chk("ps2_pins", 8'h08, {o_dp_oe, o_dp, o_dm_oe, o_dm});
		rd(8'h1a, 8'hf0, 8'h50, "ps2_in");
		host_cmd = 2'h1;
		tick(4);
		rd(8'h1a, 8'hf0, 8'h40, "ps2_data_low");
		host_cmd = 2'h0;
		wr(8'h1a, 8'hc0);
		tick(4);
		rd(8'h1a, 8'hf0, 8'hf0, "ps2_released");
		// usb: engine drive passes to the pins while the host holds SE0
		ps2_host = 1'b0;
		host_cmd = 2'h2;
		i_sie_oe = 1'b1;
		i_sie_dp = 1'b1;
		wr(8'h1b, 8'h20);
		tick(3);
		chk("sie_k", 8'h0e, {o_dp_oe, o_dp, o_dm_oe, o_dm});
		i_sie_dp = 1'b0;
		i_sie_dm = 1'b1;
		tick(3);
		chk("sie_j", 8'h0b, {o_dp_oe, o_dp, o_dm_oe, o_dm});
		i_sie_oe = 1'b0;
		host_cmd = 2'h0;
		wirq("suspend_irq");
		rd(8'h1a, 8'h09, 8'h01, "suspend");
		host_cmd = 2'h1;
		wirq("resume_irq");
		rd(8'h1a, 8'h09, 8'h09, "resume");
		host_cmd = 2'h0;
		wirq("resume_end_irq");
		rd(8'h1a, 8'h09, 8'h00, "resume_end");
		wirq("suspend_again");
		wr(8'h42, 8'h25);
		wr(8'h1a, 8'h02);
		tick(3);
		chk("wake_drive", 8'h0e, {o_dp_oe, o_dp, o_dm_oe, o_dm});
		wirq("wake_resume_irq");
		chk("host_k", 8'h02, {o_dp_oe, line_dp, line_dm});
		rd(8'h1a, 8'h09, 8'h09, "wake_resume");
		wirq("wake_end_irq");
		rd(8'h1a, 8'h09, 8'h00, "wake_end");
		finish_test;
	end
endmodule
